// ### hw/rcf_fill_policy.sv
// fill policy for the context, translation, directory and interrupt entry caches
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rcf_consts.svh"

// Behaviour
// - capability register reports whether faulting entries are kept in caches.
// - hardware default reports the flag zero; setting it is for emulation only.
// - flag clear: no context fill on root fetch error, absent or bad root.
// - flag clear: no context fill on context fetch error, absent or bad context.
// - flag clear: no context fill when reserved fields are non-zero.
// - flag set: faulting root or context results may be cached.
// - cached faulting entry without present context is tagged domain zero.
// - translation entry holds address translation plus accumulated read/write.
// - flag clear: translation cache takes only successful walks with a permission.
// - flag clear: no fill on table pointer fetch error or context faults.
// - flag clear: entry with both permissions clear is not present, not cached.
// - flag clear: bad or reserved-set table entry blocks translation fill.
// - flag clear: accumulated permissions both clear blocks translation fill.
// - flag set: erroneous translations may enter the translation cache.
// - directory cache is optional and invisible except via keep hint.
// - flag clear: faulting directory entry is not placed in directory cache.
// - flag clear: directory entry with partial permissions both clear not cached.
// - flag set: faulting directory entries may be cached.
// - interrupt entries may be held in the interrupt entry store.
// - flag clear: faulting interrupt entry not stored; flag set may store.
// - page invalidation with keep hint clear also flushes directory entries.
module rcf_fill_policy (
   input  wire logic                        i_clk,
   input  wire logic                        i_sys_rst,
   // register port
   input  wire logic [7:0]                  i_reg_addr,
   input  wire logic [31:0]                 i_reg_wdata,
   input  wire logic                        i_reg_wr,
   input  wire logic                        i_reg_rd,
   // lookup result from the walker
   input  wire logic                        i_res_valid,
   input  wire rcf_pkg::rcf_target_t        i_res_target,
   input  wire logic [`RCF_ADDR_W-1:0]      i_res_addr,
   input  wire logic [`RCF_ADDR_W-1:0]      i_res_xlat,
   input  wire logic                        i_res_ctx_present,
   input  wire logic [`RCF_DID_W-1:0]       i_res_did,
   input  wire logic                        i_root_fetch_err,
   input  wire logic                        i_root_absent,
   input  wire logic                        i_root_bad,
   input  wire logic                        i_ctx_fetch_err,
   input  wire logic                        i_ctx_absent,
   input  wire logic                        i_ctx_bad,
   input  wire logic                        i_rsvd_nonzero,
   input  wire logic                        i_tbl_fetch_err,
   input  wire logic                        i_tbl_no_perm,
   input  wire logic                        i_tbl_bad,
   input  wire logic                        i_acc_rd,
   input  wire logic                        i_acc_wr,
   input  wire logic                        i_intr_fault,
   // translation cache invalidation
   input  wire logic                        i_inv,
   input  wire rcf_pkg::rcf_inv_t           i_inv_kind,
   input  wire logic [`RCF_DID_W-1:0]       i_inv_did,
   input  wire logic [`RCF_ADDR_W-1:0]      i_inv_addr,
   input  wire logic                        i_inv_keep_hint,
   // lookup port of the translation cache
   input  wire logic [`RCF_ADDR_W-1:0]      i_look_addr,
   input  wire logic [`RCF_DID_W-1:0]       i_look_did,
   // outputs
   output logic [31:0]                      o_reg_rdata,
   output logic                             o_ctx_fill,
   output logic                             o_tlb_fill,
   output logic                             o_pde_fill,
   output logic                             o_iec_fill,
   output logic [`RCF_DID_W-1:0]            o_fill_did,
   output logic                             o_fault_report,
   output logic                             o_pde_flush,
   output logic                             o_tlb_hit,
   output logic [`RCF_ADDR_W-1:0]           o_tlb_xlat,
   output logic                             o_tlb_rd,
   output logic                             o_tlb_wr
);
   import rcf_pkg::*;

   // ==========================================================
   // control state
   // ==========================================================
   logic                     cm_flag;
   logic                     pde_en;
   logic                     iec_en;
   logic [31:0]              fill_cnt;
   logic [31:0]              drop_cnt;
   logic [31:0]              last_status;
   logic [`RCF_TLB_IDX_W:0]  tlb_count;

   logic                     ctx_fault;
   logic                     walk_fault;
   logic                     pde_fault;
   logic                     fault_any;
   logic                     next_ctx_fill;
   logic                     next_tlb_fill;
   logic                     next_pde_fill;
   logic                     next_iec_fill;
   logic [`RCF_DID_W-1:0]    next_fill_did;
   logic                     tlb_fill_now;

   // reset image of the control register, picked apart per field
   localparam logic [31:0] CTRL_RST_VAL = `RCF_CTRL_RST;

   // control register: flag resets to zero as hardware requires
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         cm_flag <= CTRL_RST_VAL[`RCF_CTRL_CM_BIT];
         pde_en  <= CTRL_RST_VAL[`RCF_CTRL_PDE_BIT];
         iec_en  <= CTRL_RST_VAL[`RCF_CTRL_IEC_BIT];
      end else if (i_reg_wr && (i_reg_addr == `RCF_REG_CTRL)) begin
         cm_flag <= i_reg_wdata[`RCF_CTRL_CM_BIT];
         pde_en  <= i_reg_wdata[`RCF_CTRL_PDE_BIT];
         iec_en  <= i_reg_wdata[`RCF_CTRL_IEC_BIT];
      end
   end

   // ==========================================================
   // fault classification
   // ==========================================================
   // root/context faults, shared by the context, translation and directory structures
   assign ctx_fault  = i_root_fetch_err | i_root_absent | i_root_bad
                     | i_ctx_fetch_err | i_ctx_absent | i_ctx_bad
                     | i_rsvd_nonzero;
   // page walk faults for the leaf cache
   assign walk_fault = ctx_fault | i_tbl_fetch_err
                     | i_tbl_no_perm
                     | i_tbl_bad
                     | ~(i_acc_rd | i_acc_wr);
   // directory faults use partial accumulated permissions
   assign pde_fault  = ctx_fault | i_tbl_fetch_err | i_tbl_no_perm | i_tbl_bad
                     | ~(i_acc_rd | i_acc_wr);

   // fault seen for the current target
   always_comb begin
      unique case (i_res_target)
         RCF_TGT_CTX: fault_any = ctx_fault;
         RCF_TGT_TLB: fault_any = walk_fault;
         RCF_TGT_PDE: fault_any = pde_fault;
         RCF_TGT_IEC: fault_any = i_intr_fault;
      endcase
   end

   // fill decisions: faulting results cached only while the flag is set
   always_comb begin
      next_ctx_fill = i_res_valid && (i_res_target == RCF_TGT_CTX)
                    && (cm_flag || !ctx_fault);
      next_tlb_fill = i_res_valid && (i_res_target == RCF_TGT_TLB)
                    && (cm_flag || !walk_fault);
      next_pde_fill = i_res_valid && (i_res_target == RCF_TGT_PDE) && pde_en
                    && (cm_flag || !pde_fault);
      next_iec_fill = i_res_valid && (i_res_target == RCF_TGT_IEC) && iec_en
                    && (cm_flag || !i_intr_fault);
   end

   // domain tag: reserved zero when no present context was found
   assign next_fill_did = i_res_ctx_present ? i_res_did : `RCF_FAULT_DID;
   assign tlb_fill_now  = next_tlb_fill;

   // ==========================================================
   // registered fill strobes
   // ==========================================================
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_ctx_fill <= 1'b0;
         o_tlb_fill <= 1'b0;
         o_pde_fill <= 1'b0;
         o_iec_fill <= 1'b0;
         o_fill_did <= '0;
      end else begin
         o_ctx_fill <= next_ctx_fill;
         o_tlb_fill <= next_tlb_fill;
         o_pde_fill <= next_pde_fill;
         o_iec_fill <= next_iec_fill;
         o_fill_did <= next_fill_did;
      end
   end

   // fault reported for every faulting result, so uncached faults recur
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_fault_report <= 1'b0;
      end else begin
         o_fault_report <= i_res_valid && fault_any;
      end
   end

   // directory flush on translation invalidations
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_pde_flush <= 1'b0;
      end else begin
         o_pde_flush <= i_inv && pde_en && ((i_inv_kind == RCF_INV_GLOBAL)
                        || (i_inv_kind == RCF_INV_DOMAIN)
                        || ((i_inv_kind == RCF_INV_PAGE) && !i_inv_keep_hint));
      end
   end

   // ==========================================================
   // statistics
   // ==========================================================
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         fill_cnt    <= '0;
         drop_cnt    <= '0;
         last_status <= '0;
      end else if (i_res_valid) begin
         if (next_ctx_fill || next_tlb_fill || next_pde_fill || next_iec_fill) begin
            fill_cnt <= fill_cnt + 32'h1;
         end else begin
            drop_cnt <= drop_cnt + 32'h1;
         end
         last_status <= {26'h0, i_acc_wr, i_acc_rd, fault_any, i_res_ctx_present,
                         i_res_target};
      end
   end

   // ==========================================================
   // translation cache
   // ==========================================================
   rcf_tlb_store u_tlb (
      .i_clk       (i_clk),
      .i_sys_rst   (i_sys_rst),
      .i_fill      (tlb_fill_now),
      .i_fill_addr (i_res_addr),
      .i_fill_xlat (i_res_xlat),
      .i_fill_did  (next_fill_did),
      .i_fill_rd   (i_acc_rd),
      .i_fill_wr   (i_acc_wr),
      .i_look_addr (i_look_addr),
      .i_look_did  (i_look_did),
      .i_inv       (i_inv),
      .i_inv_kind  (i_inv_kind),
      .i_inv_did   (i_inv_did),
      .i_inv_addr  (i_inv_addr),
      .o_hit       (o_tlb_hit),
      .o_xlat      (o_tlb_xlat),
      .o_rd        (o_tlb_rd),
      .o_wr        (o_tlb_wr),
      .o_count     (tlb_count)
   );

   // ==========================================================
   // register read port
   // ==========================================================
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_reg_rdata <= '0;
      end else if (i_reg_rd) begin
         unique case (i_reg_addr)
            `RCF_REG_CAP:     o_reg_rdata <= {31'h0, cm_flag};
            `RCF_REG_CTRL:    o_reg_rdata <= {29'h0, iec_en, pde_en, cm_flag};
            `RCF_REG_FILLCNT: o_reg_rdata <= fill_cnt;
            `RCF_REG_DROPCNT: o_reg_rdata <= drop_cnt;
            `RCF_REG_LAST:    o_reg_rdata <= last_status;
            `RCF_REG_TLBCNT:  o_reg_rdata <= {28'h0, tlb_count};
            default:          o_reg_rdata <= `RCF_UNMAPPED_RD;
         endcase
      end else begin
         o_reg_rdata <= '0;
      end
   end

   // ==========================================================
   // assertions
   // ==========================================================
   AST_CTX_NO_FAULT_FILL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_res_valid && i_res_target == RCF_TGT_CTX && ctx_fault && !cm_flag) |=> !o_ctx_fill)
      else $error("context filled with a faulting entry");
   AST_CTX_GOOD_FILL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_res_valid && i_res_target == RCF_TGT_CTX && !ctx_fault) |=> o_ctx_fill)
      else $error("clean context result not filled");
   AST_RSVD_BLOCK: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_res_valid && i_rsvd_nonzero && !cm_flag) |=> !(o_ctx_fill || o_tlb_fill || o_pde_fill))
      else $error("reserved-field entry filled");
   AST_CM_KEEP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_res_valid && i_res_target == RCF_TGT_TLB && cm_flag) |=> o_tlb_fill)
      else $error("flag set but translation not filled");
   AST_DID_ZERO: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_res_valid && !i_res_ctx_present) |=> (o_fill_did == `RCF_FAULT_DID))
      else $error("faulting entry not tagged with domain zero");
   AST_TLB_PERM: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (o_tlb_fill && !cm_flag && !$past(cm_flag)) |-> $past(i_acc_rd || i_acc_wr))
      else $error("translation filled without any permission");
   AST_WALK_FAULT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_res_valid && i_tbl_fetch_err && !cm_flag) |=> !o_tlb_fill && !o_pde_fill)
      else $error("walk fault result filled");
   AST_IEC_FAULT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_res_valid && i_res_target == RCF_TGT_IEC && i_intr_fault && !cm_flag) |=> !o_iec_fill)
      else $error("faulting interrupt entry stored");
   AST_PDE_FLUSH: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_inv && pde_en && i_inv_kind == RCF_INV_PAGE && !i_inv_keep_hint) |=> o_pde_flush)
      else $error("page invalidation did not flush directory cache");
   AST_REFAULT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_res_valid && fault_any) |=> o_fault_report)
      else $error("fault not reported");
   AST_CAP_RESET: assert property (@(posedge i_clk)
      (i_sys_rst ##1 !i_sys_rst) |-> !cm_flag)
      else $error("flag not clear after reset");

   // result decode per structure, shared by the checks below
   logic                     res_ctx;
   logic                     res_tlb;
   logic                     res_pde;
   logic                     res_iec;
   assign res_ctx = i_res_valid && (i_res_target == RCF_TGT_CTX);
   assign res_tlb = i_res_valid && (i_res_target == RCF_TGT_TLB);
   assign res_pde = i_res_valid && (i_res_target == RCF_TGT_PDE);
   assign res_iec = i_res_valid && (i_res_target == RCF_TGT_IEC);

   // leaf cache refusals with the flag clear
   AST_TLB_NOPERM: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (res_tlb && i_tbl_no_perm && !cm_flag) |=> !o_tlb_fill)
      else $error("entry without permission filled");
   AST_TLB_BAD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (res_tlb && i_tbl_bad && !cm_flag) |=> !o_tlb_fill)
      else $error("bad table entry filled");
   AST_TLB_ACC: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (res_tlb && !i_acc_rd && !i_acc_wr && !cm_flag) |=> !o_tlb_fill)
      else $error("walk without permission filled");

   // directory, context and interrupt entry policy
   AST_PDE_FAULT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (res_pde && pde_fault && !cm_flag) |=> !o_pde_fill)
      else $error("faulting directory entry filled");
   AST_PDE_PARTIAL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (res_pde && !i_acc_rd && !i_acc_wr && !cm_flag) |=> !o_pde_fill)
      else $error("directory without permission filled");
   AST_PDE_KEEP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (res_pde && pde_en && cm_flag) |=> o_pde_fill)
      else $error("directory result not kept");
   AST_CTX_KEEP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (res_ctx && cm_flag) |=> o_ctx_fill)
      else $error("context result not kept");
   AST_IEC_KEEP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (res_iec && iec_en && cm_flag) |=> o_iec_fill)
      else $error("interrupt entry not kept");
   AST_PDE_HINT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_inv && i_inv_kind == RCF_INV_PAGE && i_inv_keep_hint) |=> !o_pde_flush)
      else $error("directory flushed despite keep hint");

   COV_TLB_FILL: cover property (@(posedge i_clk) disable iff (i_sys_rst) o_tlb_fill);
   COV_FAULT_DROP: cover property (@(posedge i_clk) disable iff (i_sys_rst)
      o_fault_report && !o_tlb_fill && !o_ctx_fill);
   COV_PAGE_KEEP: cover property (@(posedge i_clk) disable iff (i_sys_rst)
      i_inv && i_inv_kind == RCF_INV_PAGE && i_inv_keep_hint);
   COV_TLB_HIT: cover property (@(posedge i_clk) disable iff (i_sys_rst) o_tlb_hit);

endmodule : rcf_fill_policy
`default_nettype wire

// ### hw/rcf_consts.svh
// constants for the remap cache fill policy block
`ifndef RCF_CONSTS_SVH
`define RCF_CONSTS_SVH

// register offsets (byte addresses, one word each)
`define RCF_REG_CAP       8'h00
`define RCF_REG_CTRL      8'h04
`define RCF_REG_FILLCNT   8'h08
`define RCF_REG_DROPCNT   8'h0c
`define RCF_REG_LAST      8'h10
`define RCF_REG_TLBCNT    8'h14

// field positions
`define RCF_CAP_CM_BIT    0
`define RCF_CTRL_CM_BIT   0
`define RCF_CTRL_PDE_BIT  1
`define RCF_CTRL_IEC_BIT  2

// reset value and unmapped read value
`define RCF_CTRL_RST      32'h0000_0006
`define RCF_UNMAPPED_RD   32'h0000_0000

// reserved domain tag for faulting entries cached without a context
`define RCF_FAULT_DID     16'h0000

// cache geometry
`define RCF_TLB_DEPTH     8
`define RCF_TLB_IDX_W     3
`define RCF_DID_W         16
`define RCF_ADDR_W        20

`endif

// ### hw/rcf_pkg.sv
// types shared by the remap cache fill policy block
package rcf_pkg;

   // structure that a lookup result targets
   typedef enum logic [1:0] {
      RCF_TGT_CTX = 2'b00,
      RCF_TGT_TLB = 2'b01,
      RCF_TGT_PDE = 2'b10,
      RCF_TGT_IEC = 2'b11
   } rcf_target_t;

   // invalidation kinds for the translation cache
   typedef enum logic [1:0] {
      RCF_INV_NONE   = 2'b00,
      RCF_INV_GLOBAL = 2'b01,
      RCF_INV_DOMAIN = 2'b10,
      RCF_INV_PAGE   = 2'b11
   } rcf_inv_t;

endpackage : rcf_pkg

// ### hw/rcf_tlb_store.sv
// small translation cache array with permission and domain tags
`timescale 1ns/1ps
`default_nettype none
`include "rcf_consts.svh"

module rcf_tlb_store (
   input  wire logic                       i_clk,
   input  wire logic                       i_sys_rst,
   input  wire logic                       i_fill,
   input  wire logic [`RCF_ADDR_W-1:0]     i_fill_addr,
   input  wire logic [`RCF_ADDR_W-1:0]     i_fill_xlat,
   input  wire logic [`RCF_DID_W-1:0]      i_fill_did,
   input  wire logic                       i_fill_rd,
   input  wire logic                       i_fill_wr,
   input  wire logic [`RCF_ADDR_W-1:0]     i_look_addr,
   input  wire logic [`RCF_DID_W-1:0]      i_look_did,
   input  wire logic                       i_inv,
   input  wire rcf_pkg::rcf_inv_t          i_inv_kind,
   input  wire logic [`RCF_DID_W-1:0]      i_inv_did,
   input  wire logic [`RCF_ADDR_W-1:0]     i_inv_addr,
   output logic                            o_hit,
   output logic [`RCF_ADDR_W-1:0]          o_xlat,
   output logic                            o_rd,
   output logic                            o_wr,
   output logic [`RCF_TLB_IDX_W:0]         o_count
);
   import rcf_pkg::*;

   logic                     valid [`RCF_TLB_DEPTH];
   logic [`RCF_ADDR_W-1:0]   tag   [`RCF_TLB_DEPTH];
   logic [`RCF_ADDR_W-1:0]   xlat  [`RCF_TLB_DEPTH];
   logic [`RCF_DID_W-1:0]    did   [`RCF_TLB_DEPTH];
   logic                     perm_rd [`RCF_TLB_DEPTH];
   logic                     perm_wr [`RCF_TLB_DEPTH];
   logic [`RCF_TLB_IDX_W-1:0] victim;

   // entry matched by an invalidation request
   function automatic logic inv_match(input rcf_inv_t k, input logic [`RCF_DID_W-1:0] ed,
                                      input logic [`RCF_ADDR_W-1:0] ea,
                                      input logic [`RCF_DID_W-1:0] qd,
                                      input logic [`RCF_ADDR_W-1:0] qa);
      inv_match = (k == RCF_INV_GLOBAL) || ((k == RCF_INV_DOMAIN) && (ed == qd)) ||
                  ((k == RCF_INV_PAGE) && (ed == qd) && (ea == qa));
   endfunction : inv_match

   // round robin victim pointer
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         victim <= '0;
      end else if (i_fill) begin
         victim <= victim + 3'h1;
      end
   end

   // entry storage, invalidation clears the valid bit; fill wins on the victim
   genvar g;
   generate
      for (g = 0; g < `RCF_TLB_DEPTH; g++) begin : g_ent
         always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
               valid[g] <= 1'b0;
            end else if (i_fill && (victim == `RCF_TLB_IDX_W'(g))) begin
               valid[g] <= 1'b1;
            end else if (i_inv && inv_match(i_inv_kind, did[g], tag[g], i_inv_did, i_inv_addr)) begin
               valid[g] <= 1'b0;
            end
         end
         always_ff @(posedge i_clk) begin
            if (i_fill && (victim == `RCF_TLB_IDX_W'(g))) begin
               tag[g]     <= i_fill_addr;
               xlat[g]    <= i_fill_xlat;
               did[g]     <= i_fill_did;
               perm_rd[g] <= i_fill_rd;
               perm_wr[g] <= i_fill_wr;
            end
         end
      end
   endgenerate

   // registered lookup and occupancy
   always_ff @(posedge i_clk) begin
      logic                     h;
      logic [`RCF_ADDR_W-1:0]   x;
      logic                     r;
      logic                     w;
      logic [`RCF_TLB_IDX_W:0]  c;
      h = 1'b0;
      x = '0;
      r = 1'b0;
      w = 1'b0;
      c = '0;
      for (int i = 0; i < `RCF_TLB_DEPTH; i++) begin
         if (valid[i]) begin
            c = c + 4'h1;
         end
         if (valid[i] && (tag[i] == i_look_addr) && (did[i] == i_look_did)) begin
            h = 1'b1;
            x = xlat[i];
            r = perm_rd[i];
            w = perm_wr[i];
         end
      end
      if (i_sys_rst) begin
         o_hit   <= 1'b0;
         o_xlat  <= '0;
         o_rd    <= 1'b0;
         o_wr    <= 1'b0;
         o_count <= '0;
      end else begin
         o_hit   <= h;
         o_xlat  <= x;
         o_rd    <= r;
         o_wr    <= w;
         o_count <= c;
      end
   end

endmodule : rcf_tlb_store
`default_nettype wire

// ### tb/rcf_dev_model.sv
// far side model: walker that hands one lookup result with its fault levels
`timescale 1ns/1ps
`default_nettype none
module rcf_dev_model (
   input  wire logic        i_clk,
   input  wire logic        i_go,
   input  wire logic [10:0] i_flt,
   output logic             o_valid,
   output logic [10:0]      o_flt
);
   // fault levels mean something only with valid; elsewhere they toggle
   always_ff @(posedge i_clk) begin
      o_valid <= i_go;
      o_flt   <= i_go ? i_flt : ~o_flt;
   end
endmodule : rcf_dev_model
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the fill policy block
`timescale 1ns/1ps
`default_nettype none
`include "rcf_consts.svh"
module tb;
   import rcf_pkg::*;
   logic clk = 0, rst = 1, rwr = 0, rrd = 0, go = 0, pres = 0, inv = 0, keep = 0;
   logic [7:0]  ra = 0;
   logic [31:0] wd = 0, rdat;
   logic [10:0] fin = 0, fl;
   logic [19:0] addr = 0, xl = 0, inva = 0, look = 20'hfffff, oxl;
   logic [15:0] did = 0, invd = 0, odid;
   logic [1:0]  acc = 0;
   rcf_target_t tgt = RCF_TGT_CTX;
   rcf_inv_t    kind = RCF_INV_NONE;
   logic vld, cf, tf, pf, ef, frep, pfl, hit, ord, owr;
   integer n_errors = 0, total_checks = 0, seed = 74, t, k, lim, cm;
   integer r, n_fill = 0, n_drop = 0, n_tlb = 0;
   logic keep_tab [2] = '{1'b1, 1'b0};
   // ==================== clock and parts
   initial forever #12.5 clk = ~clk;
   rcf_dev_model u_rcf_dev_model (.i_clk(clk), .i_go(go), .i_flt(fin), .o_valid(vld), .o_flt(fl));
   rcf_fill_policy u_rcf_fill_policy (.i_clk(clk), .i_sys_rst(rst), .i_reg_addr(ra),
      .i_reg_wdata(wd), .i_reg_wr(rwr), .i_reg_rd(rrd), .i_res_valid(vld), .i_res_target(tgt),
      .i_res_addr(addr), .i_res_xlat(xl), .i_res_ctx_present(pres), .i_res_did(did),
      .i_root_fetch_err(fl[0]), .i_root_absent(fl[1]), .i_root_bad(fl[2]),
      .i_ctx_fetch_err(fl[3]), .i_ctx_absent(fl[4]), .i_ctx_bad(fl[5]),
      .i_rsvd_nonzero(fl[6]), .i_tbl_fetch_err(fl[7]), .i_tbl_no_perm(fl[8]),
      .i_tbl_bad(fl[9]), .i_acc_rd(acc[0]), .i_acc_wr(acc[1]), .i_intr_fault(fl[10]),
      .i_inv(inv), .i_inv_kind(kind), .i_inv_did(invd), .i_inv_addr(inva),
      .i_inv_keep_hint(keep), .i_look_addr(look), .i_look_did(did), .o_reg_rdata(rdat),
      .o_ctx_fill(cf), .o_tlb_fill(tf), .o_pde_fill(pf), .o_iec_fill(ef), .o_fill_did(odid),
      .o_fault_report(frep), .o_pde_flush(pfl), .o_tlb_hit(hit), .o_tlb_xlat(oxl),
      .o_tlb_rd(ord), .o_tlb_wr(owr));
   // ==================== checking and closing
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_of_test;
      $display("errors %0d checks %0d", n_errors, total_checks);
      if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   // ==================== register bus and result tasks
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk) begin ra <= a; wd <= d; rwr <= 1; end
      @(posedge clk) rwr <= 0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk) begin ra <= a; rrd <= 1; end
      @(posedge clk) rrd <= 0;
      #1 chk(rdat, e);
   endtask : rd
   // one result through the far side model, compared with the fill rules
   task automatic res(input integer tt, input integer kk, input logic [1:0] ac);
      logic [10:0] f;
      logic bad;
      f = (kk < 11) ? 11'h1 << kk : 11'h0;
      bad = (tt == 3) ? f[10] : (tt == 0) ? |f[6:0] : (|f[9:0] || ac == 2'b00);
      @(posedge clk) begin go <= 1; fin <= f; acc <= ac; tgt <= rcf_target_t'(tt); end
      @(posedge clk) go <= 0;
      @(posedge clk) #1;
      chk({ef, pf, tf, cf}, (cm || !bad) ? 4'h1 << tt : 4'h0);
      chk(frep, bad);
      chk(odid, pres ? did : 16'h0);
      if (cm || !bad) n_fill++;
      else n_drop++;
      if (tt == 1 && (cm || !bad)) n_tlb++;
   endtask : res
   // ==================== main sequence
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      end_of_test();
   end
   initial begin
      cm = 0;
      repeat (10) @(posedge clk);
      rst <= 0;
      rd(`RCF_REG_CAP, 0);
      rd(`RCF_REG_CTRL, `RCF_CTRL_RST);
      wr(`RCF_REG_CAP, 1);
      rd(`RCF_REG_CAP, 0);
      rd(8'h20, `RCF_UNMAPPED_RD);
      for (cm = 0; cm < 2; cm++) begin
         wr(`RCF_REG_CTRL, 32'h6 | cm);
         rd(`RCF_REG_CAP, cm);
         repeat (60) begin
            t = $unsigned($random(seed)) % 4;
            lim = (t == 0) ? 7 : 10;
            k = (t == 3) ? 10 + $unsigned($random(seed)) % 2 : $unsigned($random(seed)) % (lim + 1);
            if (k == lim && t != 3) k = 11;
            r = $random(seed);
            @(posedge clk) begin pres <= r[19]; did <= r[31:16]; addr <= {1'b0, r[18:0]}; end
            res(t, k, r[21:20]);
         end
      end
      // fill a clean entry, look it up, then drop it by page invalidation
      wr(`RCF_REG_CTRL, `RCF_CTRL_RST);
      @(posedge clk) begin pres <= 1; addr <= 20'hfffff; xl <= 20'h0a5c3; did <= 16'h0012; end
      res(1, 11, 2'b11);
      @(posedge clk) #1;
      chk({hit, ord, owr, oxl}, {3'b111, 20'h0a5c3});
      foreach (keep_tab[i]) begin
         @(posedge clk) begin inv <= 1; kind <= RCF_INV_PAGE; invd <= did; inva <= addr; keep <= keep_tab[i]; end
         @(posedge clk) inv <= 0;
         #1 chk(pfl, !keep_tab[i]);
      end
      @(posedge clk) #1;
      chk(hit, 0);
      rd(`RCF_REG_FILLCNT, n_fill);
      rd(`RCF_REG_DROPCNT, n_drop);
      rd(`RCF_REG_TLBCNT, ((n_tlb < `RCF_TLB_DEPTH) ? n_tlb : `RCF_TLB_DEPTH) - 1);
      rd(`RCF_REG_LAST, 32'h35);
      end_of_test();
   end
endmodule : tb
`default_nettype wire
